// *** hdl/adc_ctrl.sv ***
// host controller for a two-bank asynchronous page-mode dram module
// assumes a 40 MHz core clock, strobes launched from flops, dq from pins
`default_nettype none
`include "adc_regs.svh"
module adc_ctrl
    import adc_pkg::*;
#(
    parameter int PAUSE_CYC   = `ADC_PAUSE_CYC,
    parameter int REF_INT_CYC = `ADC_REF_INT_CYC
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_N,
    input  wire logic                      CE,
    input  wire logic                      USE_CBR_INIT,
    input  wire logic                      REQ_VALID,
    output logic                           REQ_READY,
    input  wire adc_pkg::adc_req_s         REQ,
    output logic                           RD_VALID,
    input  wire logic                      RD_READY,
    output adc_pkg::adc_data_t             RD_DATA,
    output logic                           INIT_DONE,
    output logic                           FAST_GRADE,
    output logic                           ECC_MODULE,
    output logic [1:0]                     RAS_N,
    output logic                           CAS_N,
    output logic                           WE_N,
    output logic                           OE_N,
    output logic [`ADC_ADDR_W-1:0]         ADDR,
    output adc_pkg::adc_data_t             DQ_O,
    output logic                           DQ_OE,
    input  wire adc_pkg::adc_data_t        DQ_I,
    input  wire logic                      STRAP_ECC,
    input  wire logic                      STRAP_THREE
);
    import adc_pkg::*;

    typedef enum logic [3:0] {
        S_PAUSE   = 4'b0000,
        S_IDLE    = 4'b0001,
        S_ROW     = 4'b0010,
        S_RCD     = 4'b0011,
        S_CASLO   = 4'b0100,
        S_WEWAIT  = 4'b0101,
        S_CASHI   = 4'b0110,
        S_RASHI   = 4'b0111,
        S_CBRCAS  = 4'b1000,
        S_CBRRAS  = 4'b1001,
        S_ROREF   = 4'b1010
    } adc_state_e;

    // -------------------------------------------------------------
    // reset release and pin synchronisers
    // -------------------------------------------------------------
    logic [1:0]  rst_sync_r;
    wire         rst_n = rst_sync_r[1];
    adc_data_t   dq_s1_r, dq_s2_r;
    logic [1:0]  ecc_s_r, gr_s_r;

    // reset released through two flops
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) rst_sync_r <= 2'b00;
        else        rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // dq and straps come off the board, two flops before use
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
            ecc_s_r <= 2'b00;
            gr_s_r  <= 2'b00;
        end else if (CE) begin
            dq_s1_r <= DQ_I;
            dq_s2_r <= dq_s1_r;
            ecc_s_r <= {ecc_s_r[0], STRAP_ECC};
            gr_s_r  <= {gr_s_r[0], STRAP_THREE};
        end
    end

    // -------------------------------------------------------------
    // state, timers and pin registers
    // -------------------------------------------------------------
    adc_state_e              st_r, st_nxt;
    logic [`ADC_CNT_W-1:0]   tmr_r, tmr_nxt;
    logic [`ADC_CNT_W-1:0]   ras_r;            // row-active time
    logic [`ADC_CNT_W-1:0]   rc_r;             // since last row fall
    logic [15:0]             pause_r;
    logic [3:0]              init_r;
    logic [`ADC_CNT_W-1:0]   refint_r;
    logic                    ref_due_r;
    logic [`ADC_ADDR_W-1:0]  ref_row_r;
    logic                    ref_bank_r;
    adc_req_s                cur_r;
    logic                    open_r;
    logic                    init_done_r;
    logic [1:0]              ras_n_r;
    logic                    cas_n_r, we_n_r, oe_n_r, dq_oe_r;
    logic [`ADC_ADDR_W-1:0]  addr_r;
    adc_data_t               dq_o_r;
    logic                    cap_r;
    logic                    buf_in_ready;

    // page hit: same bank and row with page hold still set
    wire hit   = open_r && REQ_VALID && cur_r.keep_page && REQ.bank == cur_r.bank
                 && REQ.row == cur_r.row;
    wire t_done = (tmr_r == '0);
    wire ras_ok = (ras_r >= `ADC_CNT_W'(`ADC_RAS_CYC));
    wire ras_long = (ras_r >= `ADC_CNT_W'(`ADC_RAS_MAX_CYC - `ADC_RC_CYC));
    wire rc_ok  = (rc_r >= `ADC_CNT_W'(`ADC_RC_CYC));
    wire take   = (st_r == S_IDLE) && init_done_r && !ref_due_r && REQ_VALID && rc_ok
                  && buf_in_ready;
    wire take_pg = (st_r == S_CASHI) && t_done && hit && !ref_due_r && !ras_long
                   && buf_in_ready;
    wire is_wr  = (cur_r.op == ADC_OP_WRITE);
    wire is_rmw = (cur_r.op == ADC_OP_RMW);
    wire ref_go = (st_r == S_IDLE) && rc_ok && (!init_done_r ? pause_r == '0 : ref_due_r);
    wire column_before_row_refresh    = !init_done_r && USE_CBR_INIT;

    // next-state decode
    always_comb begin
        st_nxt  = st_r;
        tmr_nxt = t_done ? tmr_r : tmr_r - 1'b1;
        case (st_r)
            S_PAUSE: if (pause_r == '0) st_nxt = S_IDLE;
            S_IDLE: begin
                if (ref_go) begin
                    st_nxt  = column_before_row_refresh ? S_CBRCAS : S_ROREF;
                    tmr_nxt = `ADC_CNT_W'(column_before_row_refresh ? `ADC_CSR_CYC : `ADC_RAS_CYC);
                end else if (take) begin
                    st_nxt  = S_RCD;
                    tmr_nxt = `ADC_CNT_W'(`ADC_RCD_CYC);
                end
            end
            S_RCD: if (t_done) begin
                st_nxt  = S_CASLO;
                tmr_nxt = `ADC_CNT_W'(`ADC_CAS_CYC);
            end
            S_CASLO: if (t_done) begin
                st_nxt  = is_rmw ? S_WEWAIT : S_CASHI;
                tmr_nxt = `ADC_CNT_W'(`ADC_CP_CYC);
            end
            S_WEWAIT: if (t_done) begin
                st_nxt  = S_CASHI;
                tmr_nxt = `ADC_CNT_W'(`ADC_CP_CYC);
            end
            S_CASHI: begin
                if (take_pg) begin
                    st_nxt  = S_CASLO;
                    tmr_nxt = `ADC_CNT_W'(`ADC_CAS_CYC);
                end else if (t_done && ras_ok && !(hit && !ras_long && !ref_due_r)) begin
                    st_nxt  = S_RASHI;
                    tmr_nxt = `ADC_CNT_W'(`ADC_RP_CYC);
                end
            end
            S_ROREF, S_CBRRAS: if (t_done) begin
                st_nxt  = S_RASHI;
                tmr_nxt = `ADC_CNT_W'(`ADC_RP_CYC);
            end
            S_CBRCAS: if (t_done) begin
                st_nxt  = S_CBRRAS;
                tmr_nxt = `ADC_CNT_W'(`ADC_RAS_CYC);
            end
            S_RASHI: if (t_done) st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    // state and bookkeeping
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= S_PAUSE;
            tmr_r      <= '0;
            pause_r    <= 16'(PAUSE_CYC);
            init_r     <= '0;
            init_done_r <= 1'b0;
            cur_r      <= '0;
            open_r     <= 1'b0;
        end else if (CE) begin
            st_r    <= st_nxt;
            tmr_r   <= tmr_nxt;
            // pause is loaded at reset, so idle never starts before a full count
            if (st_r == S_PAUSE && pause_r != '0)
                pause_r <= pause_r - 1'b1;
            else if (st_r != S_PAUSE)
                pause_r <= '0;
            if (take || take_pg)
                cur_r <= REQ;
            open_r <= (st_nxt == S_RCD || st_nxt == S_CASLO || st_nxt == S_CASHI
                       || st_nxt == S_WEWAIT);
            if (!init_done_r && st_r == S_RASHI && t_done) begin
                init_r <= init_r + 1'b1;
                if (init_r == 4'(`ADC_INIT_REFRESHES - 1)) init_done_r <= 1'b1;
            end
        end
    end

    // row-active and cycle-spacing counters, saturating
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ras_r <= '0;
            rc_r  <= '1;
        end else if (CE) begin
            ras_r <= (&ras_n_r) ? '0 : (ras_r == '1 ? ras_r : ras_r + 1'b1);
            rc_r  <= (st_nxt == S_RCD && st_r == S_IDLE) || st_nxt == S_ROREF
                     || st_nxt == S_CBRRAS ? '0 : (rc_r == '1 ? rc_r : rc_r + 1'b1);
        end
    end

    // refresh interval: one bank per half-interval tick, banks alternate, row steps after bank 1
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            refint_r   <= '0;
            ref_due_r  <= 1'b0;
            ref_row_r  <= '0;
            ref_bank_r <= 1'b0;
        end else if (CE) begin
            refint_r <= (refint_r == '0) ? `ADC_CNT_W'(REF_INT_CYC / 2 - 1) : refint_r - 1'b1;
            // set wins over the clear from the refresh start
            if (init_done_r && refint_r == '0)
                ref_due_r <= 1'b1;
            else if (ref_go && init_done_r)
                ref_due_r <= 1'b0;
            if (st_r == S_ROREF && t_done) begin
                ref_bank_r <= ~ref_bank_r;
                if (ref_bank_r) ref_row_r <= ref_row_r + 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // pin drive
    // -------------------------------------------------------------
    wire [1:0] row_sel = cur_r.bank ? 2'b01 : 2'b10;  // one bank low only
    wire [1:0] ref_sel = 2'b00;                       // refresh both banks at once

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ras_n_r <= 2'b11;
            cas_n_r <= 1'b1;
            we_n_r  <= 1'b1;
            oe_n_r  <= 1'b1;
            dq_oe_r <= 1'b0;
            addr_r  <= '0;
            dq_o_r  <= '0;
            cap_r   <= 1'b0;
        end else if (CE) begin
            cap_r <= 1'b0;
            case (st_nxt)
                S_RCD: begin
                    ras_n_r <= REQ.bank ? 2'b01 : 2'b10;
                    addr_r  <= REQ.row;
                    we_n_r  <= (REQ.op != ADC_OP_WRITE);
                    oe_n_r  <= (REQ.op == ADC_OP_WRITE);
                end
                S_CASLO: begin
                    ras_n_r <= row_sel;
                    cas_n_r <= 1'b0;
                    addr_r  <= take_pg ? REQ.col : cur_r.col;
                    if (take_pg) begin
                        we_n_r  <= (REQ.op != ADC_OP_WRITE);
                        oe_n_r  <= (REQ.op == ADC_OP_WRITE);
                        dq_o_r  <= REQ.wdata;
                        dq_oe_r <= (REQ.op == ADC_OP_WRITE);
                    end else begin
                        dq_o_r  <= cur_r.wdata;
                        dq_oe_r <= is_wr;
                    end
                end
                S_WEWAIT: begin
                    oe_n_r  <= 1'b1;
                    we_n_r  <= 1'b0;
                    dq_oe_r <= 1'b1;
                    cap_r   <= (st_r == S_CASLO);
                end
                S_CASHI: begin
                    cas_n_r <= 1'b1;
                    dq_oe_r <= 1'b0;
                    cap_r   <= (st_r == S_CASLO) && !is_wr;
                end
                S_RASHI: begin
                    ras_n_r <= 2'b11;
                    cas_n_r <= 1'b1;
                    we_n_r  <= 1'b1;
                    oe_n_r  <= 1'b1;
                    dq_oe_r <= 1'b0;
                end
                S_ROREF: begin
                    ras_n_r <= ref_bank_r ? 2'b01 : 2'b10;
                    addr_r  <= ref_row_r;
                end
                S_CBRCAS: begin
                    cas_n_r <= 1'b0;
                    we_n_r  <= 1'b1;
                end
                S_CBRRAS: ras_n_r <= ref_sel;
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // read data path and straps
    // -------------------------------------------------------------
    adc_data_t rd_word;
    assign rd_word = dq_s2_r;           // sampled one cycle before column end, after access time

    adc_buf u_buf (
        .clk       (CORE_CLK),
        .rst_n     (rst_n),
        .ce        (CE),
        .in_valid  (cap_r),
        .in_ready  (buf_in_ready),
        .in_data   (rd_word),
        .out_valid (RD_VALID),
        .out_ready (RD_READY),
        .out_data  (RD_DATA)
    );

    // strap status; grounded third strap means the slower grade
    logic fast_r, ecc_r;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fast_r <= 1'b0;
            ecc_r  <= 1'b0;
        end else if (CE) begin
            fast_r <= gr_s_r[1];
            ecc_r  <= !ecc_s_r[1];
        end
    end

    assign REQ_READY  = (st_r == S_IDLE) ? take : take_pg;
    assign INIT_DONE  = init_done_r;
    assign FAST_GRADE = fast_r;
    assign ECC_MODULE = ecc_r;
    assign RAS_N      = ras_n_r;
    assign CAS_N      = cas_n_r;
    assign WE_N       = we_n_r;
    assign OE_N       = oe_n_r;
    assign ADDR       = addr_r;
    assign DQ_O       = dq_o_r;     // upper four bits unused on x36
    assign DQ_OE      = dq_oe_r;
endmodule : adc_ctrl
`default_nettype wire

// *** hdl/adc_regs.svh ***
// constants for the async dram host controller: pin timing counts and widths
// assumes a 40 MHz core clock; counts derived from ns figures by expressions
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

`define ADC_CLK_MHZ        40
`define ADC_PERIOD_NS      25
`define ADC_CEIL(ns)       (((ns) + `ADC_PERIOD_NS - 1) / `ADC_PERIOD_NS)
`define ADC_FLOOR(ns)      ((ns) / `ADC_PERIOD_NS)
// times in ns except pause (us) and refresh (ms), slow grade (-70) figures so both grades are met
`define ADC_T_PAUSE_US     200
`define ADC_PAUSE_CYC      (`ADC_T_PAUSE_US * `ADC_CLK_MHZ)
`define ADC_INIT_REFRESHES 8
`define ADC_T_RC_NS        130
`define ADC_T_RP_NS        50
`define ADC_T_RAS_NS       70
`define ADC_T_RAS_MAX_NS   10000
`define ADC_T_CAS_NS       20
`define ADC_T_CP_NS        10
`define ADC_ROW_TO_COLUMN_DELAY_NS       20
`define ADC_T_CSR_NS       10
`define ADC_T_REF_MS       64
`define ADC_REFRESH_ROWS   4096
`define ADC_REF_INT_CYC    ((`ADC_T_REF_MS * 1000 * `ADC_CLK_MHZ) / `ADC_REFRESH_ROWS)
`define ADC_RP_CYC         `ADC_CEIL(`ADC_T_RP_NS)
`define ADC_RAS_CYC        `ADC_CEIL(`ADC_T_RAS_NS)
`define ADC_RAS_MAX_CYC    `ADC_FLOOR(`ADC_T_RAS_MAX_NS)
`define ADC_CAS_CYC        `ADC_CEIL(`ADC_T_CAS_NS)
`define ADC_CP_CYC         `ADC_CEIL(`ADC_T_CP_NS)
`define ADC_RCD_CYC        `ADC_CEIL(`ADC_ROW_TO_COLUMN_DELAY_NS)
`define ADC_CSR_CYC        `ADC_CEIL(`ADC_T_CSR_NS)
`define ADC_RC_CYC         `ADC_CEIL(`ADC_T_RC_NS)
`define ADC_ADDR_W         12
`define ADC_DATA_W         40
`define ADC_DATA36_W       36
`define ADC_CNT_W          14
`define ADC_BUF_DEPTH      2

`endif

// *** hdl/adc_pkg.sv ***
// types shared by the async dram host controller
// assumes adc_regs.svh is on the include path
`default_nettype none
`include "adc_regs.svh"
package adc_pkg;
    typedef enum logic [2:0] {
        ADC_OP_READ    = 3'b000,
        ADC_OP_WRITE   = 3'b001,
        ADC_OP_RMW     = 3'b010
    } adc_op_e;

    // one request: bank, row, column, op, write data, page hold
    typedef struct packed {
        logic                    bank;
        logic [`ADC_ADDR_W-1:0]  row;
        logic [`ADC_ADDR_W-1:0]  col;
        adc_op_e                 op;
        logic [`ADC_DATA_W-1:0]  wdata;
        logic                    keep_page;
    } adc_req_s;

    typedef logic [`ADC_DATA_W-1:0] adc_data_t;
endpackage : adc_pkg
`default_nettype wire

// *** hdl/adc_buf.sv ***
// two-entry valid/ready buffer for read data
// assumes one clock, asynchronous clear from the released reset
`default_nettype none
`include "adc_regs.svh"
module adc_buf (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire logic [`ADC_DATA_W-1:0] in_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [`ADC_DATA_W-1:0]      out_data
);
    logic [`ADC_DATA_W-1:0] mem_r [`ADC_BUF_DEPTH];
    logic                   wp_r;
    logic                   rp_r;
    logic [1:0]             cnt_r;
    wire                    push = in_valid && in_ready;
    wire                    pop  = out_valid && out_ready;

    // honest full and empty from the occupancy count
    assign in_ready  = (cnt_r != 2'(`ADC_BUF_DEPTH));
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];

    // pointers and storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else if (ce) begin
            if (push) begin
                mem_r[wp_r] <= in_data;
                wp_r        <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end
endmodule : adc_buf
`default_nettype wire

// *** dv/adc_ctrl_checker.sv ***
// pin protocol assertions for the dram host controller
// assumes a bind onto adc_ctrl and strobe counts at a 40 MHz clock
`default_nettype none
module adc_ctrl_checker (
    input wire logic       CORE_CLK,
    input wire logic       RST_N,
    input wire logic [1:0] RAS_N,
    input wire logic       CAS_N,
    input wire logic       WE_N,
    input wire logic       OE_N,
    input wire logic       DQ_OE,
    input wire logic       INIT_DONE,
    input wire logic       REQ_VALID,
    input wire logic       REQ_READY
);
    // ------
    // strobe and data-bus relations
    // ------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // never fight the module's outputs
    bus_owner_a: assert property (DQ_OE |-> RAS_N != 2'b11 && OE_N)
        else $error("data driven without open row or with output on");
    drive_write_a: assert property (DQ_OE && !CAS_N |-> !WE_N)
        else $error("data driven in a column cycle that is not a write");
    cbr_entry_a: assert property ($fell(RAS_N[0]) && !CAS_N |-> WE_N && !DQ_OE)
        else $error("column-first refresh without write high");
    row_col_a: assert property ($fell(CAS_N) && RAS_N != 2'b11 |-> $past(RAS_N) != 2'b11)
        else $error("column fell in the row strobe cycle");
    row_width_a: assert property ($fell(RAS_N[0]) |-> (!RAS_N[0])[*3])
        else $error("row strobe low under three cycles");
    row_precharge_a: assert property ($rose(RAS_N[1]) |-> RAS_N[1][*2])
        else $error("row precharge under two cycles");
    // six cycles is the first whole count above the random cycle time
    cycle_time_a: assert property ($fell(RAS_N[0]) |=> (!$fell(RAS_N[0]))[*5])
        else $error("row cycles closer than six clocks");
    one_read_a: assert property (RAS_N == 2'b00 |-> OE_N)
        else $error("output enabled with both banks open");
    init_hold_a: assert property (REQ_VALID && REQ_READY |-> INIT_DONE)
        else $error("request taken before init finished");
endmodule : adc_ctrl_checker
bind adc_ctrl adc_ctrl_checker u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .RAS_N(RAS_N),
    .CAS_N(CAS_N), .WE_N(WE_N), .OE_N(OE_N), .DQ_OE(DQ_OE), .INIT_DONE(INIT_DONE),
    .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY));
`default_nettype wire

// *** dv/adc_dram_model.sv ***
// behavioural two-bank page-mode dram module seen at its pins
// assumes pins change just after clock edges; it samples 1 ns later
`default_nettype none
module adc_dram_model
    import adc_pkg::*;
(
    input  wire logic [1:0]         ras_n,
    input  wire logic               cas_n,
    input  wire logic               we_n,
    input  wire logic               oe_n,
    input  wire logic [11:0]        addr,
    input  wire adc_pkg::adc_data_t dq,
    input  wire logic               fast,
    output adc_pkg::adc_data_t      dq_drv,
    output logic                    strap_ecc,
    output logic                    strap_three
);
    timeunit 1ns;
    timeprecision 100ps;
    import adc_pkg::*;
    // ------
    // array and pins
    // ------
    adc_data_t  mem [512];
    adc_data_t  last_r = '0;
    logic [3:0] row_r [2];
    logic [3:0] col_r = '0;
    logic       cbr_r = 1'b0;
    logic       bank;
    logic       rd_en;
    // only a small corner of the array is modelled, low address bits
    initial foreach (mem[i]) mem[i] = '0;
    assign bank = ras_n[0];
    assign rd_en = ras_n != 2'b11 && !cas_n && we_n && !oe_n && !cbr_r;
    // released bus shows inverted last word, never a stale copy
    assign dq_drv = rd_en ? mem[{bank, row_r[bank], col_r}] : ~last_r;
    always @(dq_drv) if (rd_en) last_r = dq_drv;
    assign strap_ecc = 1'b0;
    assign strap_three = fast;
    // column low at row fall means refresh from the inner counter
    always @(negedge ras_n[0]) begin cbr_r = !cas_n; #1 row_r[0] = addr[3:0]; end
    always @(negedge ras_n[1]) begin cbr_r = !cas_n; #1 row_r[1] = addr[3:0]; end
    always @(posedge ras_n[0] or posedge ras_n[1]) cbr_r = 1'b0;
    always @(negedge cas_n) begin #1 col_r = addr[3:0]; if (!we_n) wr(); end
    always @(negedge we_n) begin #1 if (!cas_n) wr(); end
    task automatic wr;
        if (ras_n != 2'b11 && !cbr_r) mem[{bank, row_r[bank], col_r}] = dq;
    endtask : wr
endmodule : adc_dram_model
`default_nettype wire

// *** dv/adc_ctrl_tb_top.sv ***
// self-checking bench for the dram host controller
// assumes adc_pkg, adc_ctrl, the checker and the dram model are compiled
`default_nettype none
`define ADC_CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH %0t value differs", $time); end end
module adc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_pkg::*;
    // ------
    // harness
    // ------
    localparam int PAUSE = 20;
    localparam int REFI = 400;
    logic clk, rst_n, ce, use_cbr, req_valid, rd_ready, fast, req_ready, rd_valid;
    logic init_done, fast_grade, ecc_mod, cas_n, we_n, oe_n, dq_oe, s_ecc, s_three;
    logic [1:0] ras_n, fell;
    logic [1:0] ras_q = 2'b11;
    logic [11:0] addr;
    adc_req_s req;
    adc_data_t rd_data, dq_o, dq_i, dq_m;
    int err_count = 0, n_compared = 0, cyc = 0, first = 0, n_row = 0, n_cbr = 0;
    int n_ras = 0, n_take = 0;
    assign dq_i = dq_oe ? dq_o : dq_m;
    assign fell = ras_q & ~ras_n;
    adc_ctrl #(.PAUSE_CYC(PAUSE), .REF_INT_CYC(REFI)) dut (
        .CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .USE_CBR_INIT(use_cbr),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req), .RD_VALID(rd_valid),
        .RD_READY(rd_ready), .RD_DATA(rd_data), .INIT_DONE(init_done),
        .FAST_GRADE(fast_grade), .ECC_MODULE(ecc_mod), .RAS_N(ras_n), .CAS_N(cas_n),
        .WE_N(we_n), .OE_N(oe_n), .ADDR(addr), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_i),
        .STRAP_ECC(s_ecc), .STRAP_THREE(s_three));
    adc_dram_model mdl (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
        .addr(addr), .dq(dq_i), .fast(fast), .dq_drv(dq_m), .strap_ecc(s_ecc),
        .strap_three(s_three));
    initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
    // row strobe falls, split by kind while init runs
    always @(posedge clk) begin
        ras_q <= ras_n;
        n_ras <= n_ras + fell[0] + fell[1];
        if (req_valid && req_ready) n_take <= n_take + 1;
        if (!rst_n) begin cyc <= 0; first <= 0; n_row <= 0; n_cbr <= 0; end
        else if (!init_done) begin
            cyc <= cyc + 1;
            if (fell != 2'b00 && first == 0) first <= cyc;
            if (cas_n) n_row <= n_row + fell[0] + fell[1];
            else n_cbr <= n_cbr + fell[0];
        end
    end
    function automatic adc_data_t dat(input int k);
        return {8'hC0 + 8'(k), 32'h1357_9BDF ^ 32'(k * 7)};
    endfunction : dat
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic tmo(input int i);
        if (i >= 400) begin err_count++; $display("MISMATCH %0t wait ran out", $time); results(); end
    endtask : tmo
    // ------
    // drivers: valid stays up between chained page requests
    // ------
    task automatic send(input logic b, input logic [11:0] c, input adc_op_e op,
                        input adc_data_t w, input logic kp);
        int i;
        req = '{b, 12'h009, c, op, w, kp};
        if (!req_valid) req_valid = 1'b1;
        for (i = 0; i < 400; i++) begin
            #1;
            if (req_ready === 1'b1) break;
            @(negedge clk);
        end
        tmo(i);
        @(negedge clk);
        // a gap cycle keeps valid from dropping and rising in one step
        if (!kp) begin
            req_valid = 1'b0;
            @(negedge clk);
        end
    endtask : send
    task automatic recv(input adc_data_t e);
        int i;
        for (i = 0; i < 400 && rd_valid !== 1'b1; i++) @(negedge clk);
        tmo(i);
        `ADC_CHK(rd_data, e)
        rd_ready = 1'b1;
        @(negedge clk);
        rd_ready = 1'b0;
        @(negedge clk);
    endtask : recv
    task automatic pair(input logic b, input adc_op_e op, input adc_data_t w0, w1, e0, e1);
        fork
            begin send(b, 12'h001, op, w0, 1'b1); send(b, 12'h002, op, w1, 1'b0); end
            begin recv(e0); recv(e1); end
        join
    endtask : pair
    // ------
    // scenarios
    // ------
    task automatic s_init(input logic column_before_row_refresh, input logic f);
        int i;
        rst_n = 1'b0; use_cbr = column_before_row_refresh; fast = f;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 400 && init_done !== 1'b1; i++) @(negedge clk);
        tmo(i);
        `ADC_CHK((column_before_row_refresh ? n_cbr : n_row) >= 8, 1'b1)
        `ADC_CHK(first >= PAUSE, 1'b1)
        `ADC_CHK({fast_grade, ecc_mod}, {f, 1'b1})
    endtask : s_init
    task automatic s_page;
        int n0;
        n0 = n_ras;
        send(1'b0, 12'h001, ADC_OP_WRITE, dat(1), 1'b1);
        send(1'b0, 12'h002, ADC_OP_WRITE, dat(2), 1'b0);
        `ADC_CHK(n_ras - n0, 1)
        n0 = n_ras;
        pair(1'b0, ADC_OP_READ, '0, '0, dat(1), dat(2));
        `ADC_CHK(n_ras - n0, 1)
    endtask : s_page
    task automatic s_rmw;
        pair(1'b0, ADC_OP_RMW, dat(4), dat(5), dat(1), dat(2));
        pair(1'b0, ADC_OP_READ, '0, '0, dat(4), dat(5));
    endtask : s_rmw
    task automatic s_bank;
        send(1'b1, 12'h001, ADC_OP_WRITE, dat(9), 1'b0);
        pair(1'b1, ADC_OP_READ, '0, '0, dat(9), '0);
    endtask : s_bank
    // two words parked with the reader stalled; a third must wait
    task automatic s_buf;
        int t0;
        send(1'b0, 12'h001, ADC_OP_READ, '0, 1'b0);
        send(1'b0, 12'h002, ADC_OP_READ, '0, 1'b0);
        repeat (30) @(negedge clk);
        t0 = n_take;
        fork
            send(1'b1, 12'h001, ADC_OP_READ, '0, 1'b0);
            begin
                repeat (20) @(negedge clk);
                `ADC_CHK(n_take, t0)
                recv(dat(4));
                recv(dat(5));
                recv(dat(9));
            end
        join
    endtask : s_buf
    task automatic s_refresh;
        int n0;
        // enable low freezes everything, a due refresh included
        ce = 1'b0;
        repeat (2) @(negedge clk);
        n0 = n_ras;
        repeat (REFI / 2) @(negedge clk);
        `ADC_CHK(n_ras, n0)
        ce = 1'b1;
        n0 = n_ras;
        repeat (3 * REFI) @(negedge clk);
        `ADC_CHK(n_ras - n0 >= 5, 1'b1)
    endtask : s_refresh
    initial begin
        ce = 1'b1; req_valid = 1'b0; rd_ready = 1'b0; req = '0;
        s_init(1'b1, 1'b0);
        s_init(1'b0, 1'b1);
        s_page();
        s_rmw();
        s_bank();
        s_buf();
        s_refresh();
        results();
    end
endmodule : adc_ctrl_tb_top
`default_nettype wire
